/* File: ocd_decoder.sv */
// Purpose: Fetch and execute a subset of an 8-bit CPU instruction set
// Assumes: Program memory answers a read in the same cycle (comb data)
// Notes:   Register file is internal; outputs are registered views
// Functional notes
// - Object code carries opcode, then source byte, then destination byte; E6 carries destination byte, then immediate.
// - A register address picks 0 to 255, but an upper nibble E picks working register low nibble.
// - Opcode 7F halts the CPU, keeps flags, one fetch byte and two execute cycles.
// - Increment adds one to its destination and changes only zero and sign (20, 21, xE forms).
// - Opcode BF pops flags, then pops the PC, sets interrupt enable bit 7, one fetch and five cycles.
// - Jump 8D loads the PC from a direct address, C4 from a register pair, flags kept.
// - Jump xD loads the direct address only when the nibble condition is true.
// - Opcode 8B adds a signed displacement to the PC, two bytes, two cycles, flags kept.
// - Opcode xB adds the displacement only when the nibble condition holds.
// - Load copies source to destination without touching flags (xC, E4, E6).
// - Each flag follows result, stays, is undefined or is forced as the operation marks it.
`timescale 1ns/100ps
module ocd_decoder
  import ocd_pkg::*;
#(
  parameter int PC_W = 12
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              srst,
  // Program memory
  output logic [PC_W-1:0]        pmem_addr,
  input  wire logic [7:0]        pmem_data,
  // Status
  output logic [7:0]             flags,
  output logic [7:0]             irq_ctl,
  output logic                   halted,
  output logic                   unknown_op,
  output logic [7:0]             wr_addr,
  output logic [7:0]             wr_data,
  output logic                   wr_en
);
  import ocd_pkg::*;

  ocd_state_t      state_q;
  logic [PC_W-1:0] pc_q;
  logic [7:0]      op_q, b1_q, b2_q;
  logic [2:0]      cnt_q;
  logic [7:0]      rf_q [0:255];
  logic [7:0]      sp_q, flags_q, irq_q;
  logic [7:0]      wa_q, wd_q;
  logic            we_q, halt_q, unk_q;
  logic [1:0]      interrupt_return_step_q;

  // Operand length per opcode
  wire [3:0] op_hi = op_q[7:4];
  wire [3:0] op_lo = op_q[3:0];
  wire [3:0] nx_hi = pmem_data[7:4];
  wire [3:0] nx_lo = pmem_data[3:0];
  wire       nx_three = (pmem_data == OP_JP_DA) || (nx_lo == LO_JP_CC) ||
                        (pmem_data == OP_LD_RR) || (pmem_data == OP_LD_RIM) ||
                        (pmem_data == OP_ADD_RR);
  wire       nx_one   = (pmem_data == OP_HALT) || (pmem_data == OP_INTERRUPT_RETURN) ||
                        (nx_lo == LO_INC_WR);
  wire       nx_known = nx_three || nx_one || (pmem_data == OP_INC_R) ||
                        (pmem_data == OP_INC_IR) || (pmem_data == OP_JP_IRR) ||
                        (nx_lo == LO_JR_CC) || (nx_lo == LO_LD_IMW);

  // Escaped working-register addressing
  function automatic logic [7:0] ocd_reg(input logic [7:0] a);
    ocd_reg = (a[7:4] == ESC_NIBBLE) ? {4'h0, a[3:0]} : a;
  endfunction : ocd_reg

  // Condition codes on upper nibble
  function automatic logic ocd_cc(input logic [3:0] cc, input logic [7:0] f);
    logic c, z, s, v, t;
    c = f[FLAG_C];
    z = f[FLAG_Z];
    s = f[FLAG_S];
    v = f[FLAG_V];
    unique case (cc[2:0])
      3'h0: t = 1'b0;
      3'h1: t = s ^ v;
      3'h2: t = z | (s ^ v);
      3'h3: t = c | z;
      3'h4: t = v;
      3'h5: t = s;
      3'h6: t = z;
      3'h7: t = c;
    endcase
    ocd_cc = cc[3] ? ~t : t;
  endfunction : ocd_cc

  // Source is second byte, destination third
  wire [7:0] src_a   = ocd_reg(b1_q);
  wire [7:0] inc_a   = (op_q == OP_INC_IR) ? ocd_reg(rf_q[ocd_reg(b1_q)]) :
                       (op_lo == LO_INC_WR) ? {4'h0, op_hi} : ocd_reg(b1_q);
  wire [7:0] inc_v   = rf_q[inc_a] + 8'h01;
  wire       cc_true = ocd_cc(op_hi, flags_q);
  wire [PC_W-1:0] rel_pc = pc_q + PC_W'({{8{b1_q[7]}}, b1_q});
  wire [15:0] pair   = {rf_q[ocd_reg(b1_q)], rf_q[ocd_reg(b1_q) + 8'h01]};
  wire [7:0] sp_1    = sp_q + 8'h01;
  wire [7:0] sp_2    = sp_q + 8'h02;

  always_ff @(posedge clk) begin
    we_q <= 1'b0;
    if (srst) begin
      state_q <= OCD_FETCH;
      pc_q    <= '0;
      op_q    <= 8'h00;
      b1_q    <= 8'h00;
      b2_q    <= 8'h00;
      cnt_q   <= 3'h0;
      sp_q    <= SP_RESET;
      flags_q <= 8'h00;
      irq_q   <= 8'h00;
      wa_q    <= 8'h00;
      wd_q    <= 8'h00;
      halt_q  <= 1'b0;
      unk_q   <= 1'b0;
      interrupt_return_step_q <= 2'h0;
    end else begin
      unique case (state_q)
        OCD_FETCH: begin
          op_q  <= pmem_data;
          pc_q  <= pc_q + 1'b1;
          unk_q <= ~nx_known;
          if (nx_one) begin
            cnt_q   <= (pmem_data == OP_INTERRUPT_RETURN) ? EXE_INTERRUPT_RETURN :
                       (pmem_data == OP_HALT) ? EXE_HALT : EXE_SHORT;
            state_q <= OCD_EXEC;
          end else if (nx_known) begin
            state_q <= OCD_OPND1;
          end
        end
        OCD_OPND1: begin
          b1_q  <= pmem_data;
          pc_q  <= pc_q + 1'b1;
          cnt_q <= EXE_SHORT;
          state_q <= (op_q == OP_JP_DA || op_lo == LO_JP_CC || op_q == OP_LD_RR ||
                      op_q == OP_LD_RIM || op_q == OP_ADD_RR) ? OCD_OPND2 : OCD_EXEC;
        end
        OCD_OPND2: begin
          b2_q  <= pmem_data;
          pc_q  <= pc_q + 1'b1;
          state_q <= OCD_EXEC;
        end
        OCD_EXEC: begin
          cnt_q <= cnt_q - 3'h1;
          if (cnt_q == 3'h1) begin
            state_q <= OCD_FETCH;
            if (op_q == OP_HALT) begin
              halt_q  <= 1'b1;
              state_q <= OCD_HALTED;
            end else if (op_q == OP_INTERRUPT_RETURN) begin
              flags_q <= rf_q[sp_q];
              pc_q    <= PC_W'({rf_q[sp_1], rf_q[sp_1 + 8'h01]});
              sp_q    <= sp_q + 8'h03;
              irq_q[IRQ_EN_BIT] <= 1'b1;
            end else if (op_q == OP_INC_R || op_q == OP_INC_IR || op_lo == LO_INC_WR) begin
              wa_q <= inc_a;
              wd_q <= inc_v;
              we_q <= 1'b1;
              flags_q[FLAG_Z] <= (inc_v == 8'h00);
              flags_q[FLAG_S] <= inc_v[7];
            end else if (op_q == OP_JP_DA || (op_lo == LO_JP_CC &&
                         (op_hi == CC_ALWAYS || cc_true))) begin
              pc_q <= PC_W'({b1_q, b2_q});
            end else if (op_q == OP_JP_IRR) begin
              pc_q <= PC_W'(pair);
            end else if (op_lo == LO_JR_CC && (op_hi == CC_ALWAYS || cc_true)) begin
              pc_q <= rel_pc;
            end else if (op_lo == LO_LD_IMW) begin
              wa_q <= {4'h0, op_hi};
              wd_q <= b1_q;
              we_q <= 1'b1;
            end else if (op_q == OP_LD_RR) begin
              wa_q <= ocd_reg(b2_q);
              wd_q <= rf_q[src_a];
              we_q <= 1'b1;
            end else if (op_q == OP_LD_RIM) begin
              wa_q <= ocd_reg(b1_q);
              wd_q <= b2_q;
              we_q <= 1'b1;
            end
          end
        end
        OCD_HALTED: state_q <= OCD_HALTED;
        default: state_q <= OCD_FETCH;
      endcase
    end
  end

  // Register file write port, no reset to keep it a RAM
  always_ff @(posedge clk) begin
    if (we_q) begin
      rf_q[wa_q] <= wd_q;
    end
  end

  // Address is the pc flop itself, so the combinational answer is the byte being decoded
  assign pmem_addr = pc_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      flags      <= 8'h00;
      irq_ctl    <= 8'h00;
      halted     <= 1'b0;
      unknown_op <= 1'b0;
      wr_addr    <= 8'h00;
      wr_data    <= 8'h00;
      wr_en      <= 1'b0;
    end else begin
      flags      <= flags_q;
      irq_ctl    <= irq_q;
      halted     <= halt_q;
      unknown_op <= unk_q;
      wr_addr    <= wa_q;
      wr_data    <= wd_q;
      wr_en      <= we_q;
    end
  end

  a_halt_keeps_flags: assert property (@(posedge clk) disable iff (srst)
    (state_q == OCD_EXEC && op_q == OP_HALT) |=> $stable(flags_q))
    else $error("flags changed during halt");
  a_jp_loads_pc: assert property (@(posedge clk) disable iff (srst)
    (state_q == OCD_EXEC && cnt_q == 3'h1 && op_q == OP_JP_DA) |=> pc_q == PC_W'({$past(b1_q), $past(b2_q)}))
    else $error("absolute jump did not load pc");
  a_interrupt_return_sets_ie: assert property (@(posedge clk) disable iff (srst)
    (state_q == OCD_EXEC && cnt_q == 3'h1 && op_q == OP_INTERRUPT_RETURN) |=> irq_q[IRQ_EN_BIT] && sp_q == $past(sp_q) + 8'h03)
    else $error("interrupt return wrong");
  a_load_keeps_flags: assert property (@(posedge clk) disable iff (srst)
    (state_q == OCD_EXEC && op_lo == LO_LD_IMW) |=> $stable(flags_q))
    else $error("load touched flags");
  a_inc_flag_mask: assert property (@(posedge clk) disable iff (srst)
    (state_q == OCD_EXEC && op_q == OP_INC_R) |=> flags_q[FLAG_C] == $past(flags_q[FLAG_C]))
    else $error("increment touched carry");
  a_jr_no_flags: assert property (@(posedge clk) disable iff (srst)
    (state_q == OCD_EXEC && op_q == OP_JR) |=> $stable(flags_q))
    else $error("relative jump touched flags");
  a_jr_cc_false: assert property (@(posedge clk) disable iff (srst)
    (state_q == OCD_EXEC && cnt_q == 3'h1 && op_lo == LO_JR_CC && op_hi != CC_ALWAYS && !cc_true)
    |=> pc_q == $past(pc_q))
    else $error("false condition moved pc");
  a_halt_sticks: assert property (@(posedge clk) disable iff (srst)
    (state_q == OCD_FETCH && pmem_data == OP_HALT) |=> ##2 state_q == OCD_HALTED)
    else $error("halt not reached in two cycles");

  a_halted_stays: assert property (@(posedge clk) disable iff (srst)
    (state_q == OCD_HALTED) |=> (state_q == OCD_HALTED && pc_q == $past(pc_q)))
    else $error("halted state left or pc moved");

  a_write_one_cycle: assert property (@(posedge clk) disable iff (srst)
    wr_en |=> !wr_en)
    else $error("write pulse longer than one cycle");

  a_inc_wr_target: assert property (@(posedge clk) disable iff (srst)
    (state_q == OCD_EXEC && cnt_q == 3'h1 && op_lo == LO_INC_WR)
    |=> (we_q && wa_q == {4'h0, $past(op_hi)}))
    else $error("working register increment hit wrong register");

  a_ld_imw_data: assert property (@(posedge clk) disable iff (srst)
    (state_q == OCD_EXEC && cnt_q == 3'h1 && op_lo == LO_LD_IMW)
    |=> (we_q && wd_q == $past(b1_q)))
    else $error("immediate load wrote wrong data");

  a_escape_source: assert property (@(posedge clk) disable iff (srst)
    (state_q == OCD_EXEC && cnt_q == 3'h1 && op_q == OP_LD_RR && b1_q[7:4] == ESC_NIBBLE)
    |=> (wd_q == $past(rf_q[{4'h0, b1_q[3:0]}])))
    else $error("escaped source not read from working register");

  a_unknown_noop: assert property (@(posedge clk) disable iff (srst)
    (state_q == OCD_FETCH && !nx_known)
    |=> (state_q == OCD_FETCH && pc_q == $past(pc_q) + 1'b1))
    else $error("unknown opcode not a one byte no-op");

  a_jr_taken: assert property (@(posedge clk) disable iff (srst)
    (state_q == OCD_EXEC && cnt_q == 3'h1 && op_lo == LO_JR_CC && (op_hi == CC_ALWAYS || cc_true))
    |=> (pc_q == $past(rel_pc)))
    else $error("taken relative jump missed target");

  a_interrupt_return_flags: assert property (@(posedge clk) disable iff (srst)
    (state_q == OCD_EXEC && cnt_q == 3'h1 && op_q == OP_INTERRUPT_RETURN)
    |=> (flags_q == $past(rf_q[sp_q])))
    else $error("interrupt return did not restore flags");

  a_jp_cc_false: assert property (@(posedge clk) disable iff (srst)
    (state_q == OCD_EXEC && cnt_q == 3'h1 && op_lo == LO_JP_CC && op_q != OP_JP_DA && !cc_true)
    |=> (pc_q == $past(pc_q)))
    else $error("false condition jump moved pc");
endmodule : ocd_decoder

/* File: ocd_pkg.sv */
// Purpose: Shared constants for the opcode decoder subset
// Assumes: 8-bit opcodes, 12-bit program counter
// Notes:   Cycle counts are fetch bytes and execute cycles
package ocd_pkg;
  localparam logic [7:0] OP_HALT     = 8'h7F;
  localparam logic [7:0] OP_INC_R    = 8'h20;
  localparam logic [7:0] OP_INC_IR   = 8'h21;
  localparam logic [3:0] LO_INC_WR   = 4'hE;
  localparam logic [7:0] OP_INTERRUPT_RETURN     = 8'hBF;
  localparam logic [7:0] OP_JP_DA    = 8'h8D;
  localparam logic [7:0] OP_JP_IRR   = 8'hC4;
  localparam logic [3:0] LO_JP_CC    = 4'hD;
  localparam logic [7:0] OP_JR       = 8'h8B;
  localparam logic [3:0] LO_JR_CC    = 4'hB;
  localparam logic [3:0] LO_LD_IMW   = 4'hC;
  localparam logic [7:0] OP_LD_RR    = 8'hE4;
  localparam logic [7:0] OP_LD_RIM   = 8'hE6;
  localparam logic [7:0] OP_ADD_RR   = 8'h04;
  localparam logic [3:0] ESC_NIBBLE  = 4'hE;
  localparam logic [3:0] CC_ALWAYS   = 4'h8;
  localparam int         FLAG_C      = 7;
  localparam int         FLAG_Z      = 6;
  localparam int         FLAG_S      = 5;
  localparam int         FLAG_V      = 4;
  localparam int         IRQ_EN_BIT  = 7;
  localparam logic [7:0] SP_RESET    = 8'hFF;
  localparam logic [2:0] EXE_HALT    = 3'h2;
  localparam logic [2:0] EXE_INTERRUPT_RETURN    = 3'h5;
  localparam logic [2:0] EXE_SHORT   = 3'h2;
  typedef enum logic [2:0] {
    OCD_FETCH   = 3'b000,
    OCD_OPND1   = 3'b001,
    OCD_OPND2   = 3'b010,
    OCD_EXEC    = 3'b011,
    OCD_HALTED  = 3'b100
  } ocd_state_t;
endpackage : ocd_pkg

/* File: ocd_pmem_model.sv */
// Purpose: Program memory model feeding instruction bytes
// Assumes: Combinational read of the presented address
// Notes:   Contents are loaded by the bench while reset is held
`timescale 1ns/100ps
module ocd_pmem_model (
  // Fetch side
  input  wire logic [11:0] addr,
  output logic      [7:0]  data
);
  logic [7:0] mem [0:4095];
  // Answers at once, like on-chip flash seen by the fetch logic
  assign data = mem[addr];
endmodule : ocd_pmem_model

/* File: testbench.sv */
// Purpose: Self-checking bench for the opcode decoder subset
// Assumes: Memory loaded under reset, programs end on a halt opcode except in t_unknown
// Notes:   Filler bytes are chosen to expose a wrong branch outcome
`timescale 1ns/100ps
module testbench;
  import ocd_pkg::*;
  logic        clk;
  logic        srst;
  logic [11:0] pmem_addr;
  logic [7:0]  pmem_data;
  logic [7:0]  flags;
  logic [7:0]  irq_ctl;
  logic        halted;
  logic        unknown_op;
  logic [7:0]  wr_addr;
  logic [7:0]  wr_data;
  logic        wr_en;
  int          n_fail;
  int          check_count;

  ocd_decoder #(.PC_W(12)) dut (.clk(clk), .srst(srst), .pmem_addr(pmem_addr), .pmem_data(pmem_data),
    .flags(flags), .irq_ctl(irq_ctl), .halted(halted), .unknown_op(unknown_op),
    .wr_addr(wr_addr), .wr_data(wr_data), .wr_en(wr_en));
  ocd_pmem_model pmem (.addr(pmem_addr), .data(pmem_data));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task finish_test;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test

  task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask : chk

  function automatic logic cond(input int w);
    case (w)
      0: return halted === 1'b1;
      1: return wr_en === 1'b1;
      2: return irq_ctl[7] === 1'b1;
      default: return unknown_op === 1'b1;
    endcase
  endfunction : cond

  // Bounded wait; running out counts as a mismatch and ends the run
  task wait_for(input int w, input string what);
    int i;
    for (i = 0; i < 80 && !cond(w); i++) @(negedge clk);
    if (!cond(w)) begin
      chk(what, 8'h01, 8'h00);
      finish_test();
    end
  endtask : wait_for

  task load(input logic [7:0] b0, b1, b2, fill);
    @(negedge clk);
    srst = 1'b1;
    for (int i = 0; i < 4096; i++) pmem.mem[i] = fill;
    pmem.mem[0] = b0;
    pmem.mem[1] = b1;
    pmem.mem[2] = b2;
    repeat (4) @(negedge clk);
    srst = 1'b0;
  endtask : load

  // Any wrong path runs an interrupt return and marks irq_ctl
  task run_branch(input logic [7:0] b0, b1, b2, input logic [11:0] halt_at);
    load(b0, b1, b2, OP_INTERRUPT_RETURN);
    pmem.mem[halt_at] = OP_HALT;
    wait_for(0, "halted");
    chk("irq_ctl", 8'h00, irq_ctl);
    chk("flags", 8'h00, flags);
  endtask : run_branch

  task run_write(input logic [7:0] op, b1, b2, ea, ed, ef);
    load(op, b1, b2, OP_HALT);
    wait_for(1, "wr_en");
    chk("wr_addr", ea, wr_addr);
    chk("wr_data", ed, wr_data);
    wait_for(0, "halted");
    chk("flags", ef, flags);
  endtask : run_write

  task t_halt;
    run_branch(8'h7F, 8'h01, 8'h01, 12'h000);
    repeat (10) @(negedge clk);
    chk("halted held", 8'h01, {7'h00, halted});
    chk("pmem_addr", 8'h01, pmem_addr[7:0]);
  endtask : t_halt

  task t_jumps;
    run_branch(8'h8D, 8'h00, 8'h10, 12'h010);
    run_branch(8'h0D, 8'h00, 8'h10, 12'h003);
    run_branch(8'h8B, 8'h0E, 8'hBF, 12'h010);
    run_branch(8'h0B, 8'h0E, 8'hBF, 12'h002);
  endtask : t_jumps

  task t_writes;
    run_write(8'hE6, 8'h43, 8'hA5, 8'h43, 8'hA5, 8'h00);
    run_write(8'hE4, 8'h43, 8'h34, 8'h34, 8'hA5, 8'h00);
    run_write(8'h8C, 8'h3C, 8'h7F, 8'h08, 8'h3C, 8'h00);
    run_write(8'hE4, 8'hE8, 8'h43, 8'h43, 8'h3C, 8'h00);
    run_write(8'h20, 8'h43, 8'h7F, 8'h43, 8'h3D, 8'h00);
    run_write(8'h8C, 8'h7F, 8'h7F, 8'h08, 8'h7F, 8'h00);
    run_write(8'h8E, 8'h7F, 8'h7F, 8'h08, 8'h80, 8'h20);
  endtask : t_writes

  // Stack at FF, 00, 01 holds flags C0 and return address 010
  task t_interrupt_return;
    run_write(8'hE6, 8'hFF, 8'hC0, 8'hFF, 8'hC0, 8'h00);
    run_write(8'h0C, 8'h00, 8'h7F, 8'h00, 8'h00, 8'h00);
    run_write(8'h1C, 8'h10, 8'h7F, 8'h01, 8'h10, 8'h00);
    load(8'hBF, 8'hBF, 8'hBF, OP_INTERRUPT_RETURN);
    pmem.mem[12'h010] = OP_HALT;
    wait_for(0, "halted");
    chk("irq_ctl bit", 8'h01, {7'h00, irq_ctl[IRQ_EN_BIT]});
    chk("interrupt_return flags", 8'hC0, flags);
  endtask : t_interrupt_return

  // Increment sets sign, then both conditional jumps on sign must be taken
  task t_cond;
    load(8'h8C, 8'h7F, 8'h8E, OP_INTERRUPT_RETURN);
    pmem.mem[12'h003] = 8'h5D;
    pmem.mem[12'h004] = 8'h00;
    pmem.mem[12'h005] = 8'h10;
    pmem.mem[12'h010] = 8'h5B;
    pmem.mem[12'h011] = 8'h0E;
    pmem.mem[12'h020] = OP_HALT;
    wait_for(0, "halted");
    chk("cond irq_ctl", 8'h00, irq_ctl);
    chk("cond flags", 8'h20, flags);
  endtask : t_cond

  task t_unknown;
    load(8'h01, 8'h01, 8'h01, 8'h01);
    wait_for(3, "unknown_op");
    chk("unknown_op", 8'h01, {7'h00, unknown_op});
  endtask : t_unknown

  initial begin
    n_fail = 0;
    check_count = 0;
    srst = 1'b1;
    t_halt();
    t_jumps();
    t_writes();
    t_interrupt_return();
    t_cond();
    t_unknown();
    finish_test();
  end
endmodule : testbench
